// ---- sfe_pkg.sv ----
/*
  sfe_pkg: sizes, register map, reset values and helper functions of the
  switch frame engine. Assumes one core clock; ports 0 and 1 are fast
  ports, port 2 the gigabit port, port 3 the processor port.
*/
package sfe_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NP           = 4;
  localparam int NC           = 4;
  localparam int PW           = 2;
  localparam int WORD_BYTES   = 8;
  localparam int BLOCK_BYTES  = 128;
  localparam int BLOCK_WORDS  = BLOCK_BYTES / WORD_BYTES;
  localparam int HDR_WORDS    = 64 / WORD_BYTES;
  localparam int FAST_PORTS   = 2;
  localparam int FAST_CLASSES = 2;
  localparam int WIDE_CLASSES = 4;
  localparam logic [12:0] MAX_STD  = 13'h05EE;
  localparam logic [12:0] MAX_TAG  = 13'h05F2;
  localparam logic [7:0]  TPID_HI  = 8'h81;
  localparam logic [7:0]  TPID_LO  = 8'h00;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] REG_PORT0     = 4'h0;
  localparam logic [3:0] REG_BUF_LIMIT = 4'h4;
  localparam logic [3:0] REG_QLIMIT    = 4'h5;
  localparam logic [3:0] REG_RESERVE   = 4'h6;
  localparam logic [3:0] REG_FREE      = 4'h7;
  localparam logic [3:0] REG_DROPS     = 4'h8;
  localparam logic [3:0] REG_STATUS    = 4'h9;
  localparam int PCTL_FC  = 0;
  localparam int PCTL_BIG = 1;
  localparam logic [1:0]  PCTL_RST      = 2'h0;
  localparam logic [12:0] BUF_LIMIT_RST = 13'h1000;
  localparam logic [7:0]  QLIMIT_RST    = 8'h08;
  localparam logic [7:0]  RESERVE_RST   = 8'h08;
  // ****************************************
  // types and helpers
  // ****************************************
  typedef enum logic {TX_IDLE, TX_SEND} sfe_tx_t;
  // round robin: nearest request after the last grant wins
  function automatic logic [PW-1:0] rrPick(input logic [NP-1:0] req,
                                           input logic [PW-1:0] last);
    logic [PW-1:0] idx;
    logic [PW-1:0] pick;
    pick = last;
    for (int i = NP; i >= 1; i--) begin
      idx = PW'(int'(last) + i);
      if (req[idx]) pick = idx;
    end
    return pick;
  endfunction : rrPick
  // class queue used on a port for a four-level class
  function automatic logic [1:0] portCls(input int p, input logic [1:0] c);
    return (p < FAST_PORTS) ? {1'b0, c[1]} : c;
  endfunction : portCls
endpackage : sfe_pkg

// ---- sfe_frame_engine.sv ----
/*
  sfe_frame_engine: frame engine of a small managed switch, from receive
  fifo to shared frame buffer, search hand-off, drop decision, class
  queues, scheduling and transmit streaming, with block and control block
  management. Assumes port MACs and the search engine are synchronous
  logic on mclk and hold a word until it is taken.
*/
// How it works
// - receive data is written into the frame buffer one 8-byte word at a time
// - a search response's class and drop precedence are judged before forwarding
// - fast ports use two class queues, gigabit and processor ports four
// - unicast jobs join a linked list, multicast ones a physical queue
// - of the unicast and multicast heads of one queue the older goes first
// - a port ready for a frame gets the head of its chosen class queue
// - the transmit mover streams a frame word by word to its transmit fifo
// - each arriving frame gets a control block, freed when it departs
// - buffer is kept in 128-byte blocks, all chained free at start-up
// - a receiving port gets blocks on demand, released chains go back free
// - frame limit 1518, 1522 tagged, or the programmed limit when enabled
// - a switch request is made only for a frame ending with good status
// - receive ports are arbitrated, first 64 bytes kept for the search
// - drop decision uses class queue occupancy and global reserve
// - sources without flow control drop rather than block the head
// - kept multicast frames enter the multicast queue of each destination port and set a copy count
// - flow control is asserted only toward sources that enable it
// - a scheduled frame's control block loads the transmit port logic
// - read addresses follow the block chain, start and end are flagged
// - the last finished copy of a frame requests release of the frame's buffer
// - one transmit path is shared and release requests are arbitrated
// - a global block reserve is kept for low drop traffic
`timescale 1ns/100ps
`default_nettype none
module sfe_frame_engine
  import sfe_pkg::*;
#(
  parameter  int NBLK = 64,
  parameter  int NFCB = 16,
  parameter  int MQD  = 4,
  localparam int BW   = $clog2(NBLK),
  localparam int FW   = $clog2(NFCB),
  localparam int MW   = $clog2(MQD)
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic [3:0]          regAddr,
  input  wire logic [15:0]         regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [15:0]         regRdata,
  input  wire logic [NP-1:0]       rxValid,
  input  wire logic [NP-1:0][63:0] rxData,
  input  wire logic [NP-1:0]       rxSof,
  input  wire logic [NP-1:0]       rxEof,
  input  wire logic [NP-1:0]       rxGood,
  input  wire logic [NP-1:0][2:0]  rxLastBytes,
  output logic      [NP-1:0]       rxReady,
  output logic                     srchReq,
  output logic      [PW-1:0]       srchPort,
  output logic      [FW-1:0]       srchFcb,
  input  wire logic [FW-1:0]       srchHdrFcb,
  input  wire logic [2:0]          srchHdrIdx,
  output logic      [63:0]         srchHdr,
  input  wire logic                rspValid,
  input  wire logic [FW-1:0]       rspFcb,
  input  wire logic                rspMcast,
  input  wire logic [NP-1:0]       rspPorts,
  input  wire logic [1:0]          rspClass,
  input  wire logic                rspDropHigh,
  output logic      [NP-1:0]       fcPause,
  input  wire logic [NP-1:0]       txAccept,
  output logic                     txValid,
  output logic      [PW-1:0]       txPort,
  output logic      [63:0]         txData,
  output logic                     txSof,
  output logic                     txEof,
  output logic      [2:0]          txLastBytes
);
  // ****************************************
  // storage
  // ****************************************
  logic [63:0]   frameMem [NBLK*BLOCK_WORDS];
  logic [63:0]   hdrMem   [NFCB*HDR_WORDS];
  logic [BW-1:0] nextBlk  [NBLK];
  logic [BW-1:0] fcbHead  [NFCB];
  logic [BW-1:0] fcbTail  [NFCB];
  logic [BW:0]   fcbBlks  [NFCB];
  logic [12:0]   fcbLen   [NFCB];
  logic [PW-1:0] fcbSrc   [NFCB];
  logic [FW-1:0] fcbNext  [NFCB];
  logic [7:0]    fcbStamp [NFCB];
  logic [2:0]    fcbCopies[NFCB];
  logic          fcbMc    [NFCB];
  logic [FW-1:0] mqMem    [NP][NC][MQD];
  logic [FW-1:0] ucHead   [NP][NC];
  logic [FW-1:0] ucTail   [NP][NC];
  logic [7:0]    ucCnt    [NP][NC];
  logic [MW-1:0] mqRd     [NP][NC];
  logic [MW-1:0] mqWr     [NP][NC];
  logic [MW:0]   mqCnt    [NP][NC];
  logic [NP-1:0][1:0] portCtrl;
  logic [12:0]   bufLimit;
  logic [7:0]    qLimit;
  logic [7:0]    reserve;
  logic [15:0]   dropCnt;
  logic          initDone;
  logic [BW-1:0] initIdx;
  logic [BW-1:0] freeHead;
  logic [BW:0]   freeCnt;
  logic [NFCB-1:0] fcbUsed;
  logic [NFCB-1:0] fcbRel;
  logic [FW-1:0] relPtr;
  logic [7:0]    seq;
  logic          rxBusy;
  logic [PW-1:0] rxPort;
  logic [PW-1:0] rxRr;
  logic [FW-1:0] rxFcb;
  logic [BW-1:0] rxBlk;
  logic [BW:0]   rxBlks;
  logic [3:0]    rxWord;
  logic [12:0]   rxLen;
  logic          rxErr;
  logic          rxTag;
  sfe_tx_t       txState;
  logic [FW-1:0] txFcb;
  logic [BW-1:0] txBlk;
  logic [3:0]    txWord;
  logic [12:0]   txLeft;
  logic          txFirst;
  // ****************************************
  // receive side decode
  // ****************************************
  logic          rxAcc, rxRoll, rxNoBlk, rxDone, rxBad, rxGrant;
  logic [12:0]   rxLenNext, rxLimit;
  logic [PW-1:0] rxPick;
  logic [FW-1:0] freeF;
  logic          alloc;
  // word taken, block roll-over and end of frame
  always_comb begin
    rxAcc     = rxBusy & rxValid[rxPort] & rxReady[rxPort];
    rxNoBlk   = rxWord == 4'hF && !rxEof[rxPort] && freeCnt == '0;
    rxRoll    = rxAcc & ~rxEof[rxPort] & (rxWord == 4'hF) & ~rxErr & ~rxNoBlk;
    rxLenNext = rxLen + ((rxEof[rxPort] && rxLastBytes[rxPort] != 3'h0) ?
                13'(rxLastBytes[rxPort]) : 13'(WORD_BYTES));
    rxLimit   = portCtrl[rxPort][PCTL_BIG] ? bufLimit :
                (rxTag ? MAX_TAG : MAX_STD);
    rxDone    = rxAcc & rxEof[rxPort];
    rxBad     = rxErr | rxNoBlk | (rxLenNext > rxLimit) | ~rxGood[rxPort];
    rxPick    = rrPick(rxValid & rxSof, rxRr);
    freeF     = '0;
    for (int i = NFCB - 1; i >= 0; i--) begin
      if (!fcbUsed[i]) freeF = FW'(i);
    end
    rxGrant   = ~rxBusy & initDone & |(rxValid & rxSof) & ~&fcbUsed &
                (freeCnt != '0);
    alloc     = rxGrant | rxRoll;
  end
  // ****************************************
  // response decode: drop decision
  // ****************************************
  logic          rspDrop, rspKeep, congested, hardFull, anyCong, shortBuf, srcFc;
  logic [PW-1:0] ucDest;
  logic [2:0]    copies;
  logic [8:0]    occ;
  // queue occupancy against limit and global reserve
  always_comb begin
    congested = 1'b0;
    hardFull  = 1'b0;
    anyCong   = 1'b0;
    copies    = 3'h0;
    ucDest    = '0;
    occ       = '0;
    for (int p = NP - 1; p >= 0; p--) begin
      for (int c = 0; c < NC; c++) begin
        occ = 9'(ucCnt[p][c]) + 9'(mqCnt[p][c]);
        if (occ >= 9'(qLimit)) anyCong = 1'b1;
      end
      occ = 9'(ucCnt[p][portCls(p, rspClass)]) + 9'(mqCnt[p][portCls(p, rspClass)]);
      if (rspPorts[p]) begin
        ucDest = PW'(p);
        copies = copies + 3'h1;
        if (occ >= 9'(qLimit)) congested = 1'b1;
        if (mqCnt[p][portCls(p, rspClass)] == (MW+1)'(MQD) ||
            ucCnt[p][portCls(p, rspClass)] == 8'hFF) hardFull = 1'b1;
      end
    end
    shortBuf = freeCnt < (BW+1)'(reserve);
    srcFc    = portCtrl[fcbSrc[rspFcb]][PCTL_FC];
    rspDrop  = rspValid & ((rspPorts == '0) | hardFull |
               (shortBuf & rspDropHigh) | (congested & ~srcFc));
    rspKeep  = rspValid & ~rspDrop;
  end
  // ****************************************
  // scheduler decode
  // ****************************************
  logic [NP-1:0] hasWork;
  logic          schedGo, useMc, txFinal, lastCopy;
  logic [PW-1:0] sp, txRr;
  logic [1:0]    sc;
  logic [FW-1:0] deqF, mcF;
  // strict priority within the port, older head between list and queue
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      hasWork[p] = 1'b0;
      for (int c = 0; c < NC; c++) begin
        if (ucCnt[p][c] != 8'h00 || mqCnt[p][c] != '0) hasWork[p] = 1'b1;
      end
    end
    schedGo = (txState == TX_IDLE) & |(hasWork & txAccept);
    sp      = rrPick(hasWork & txAccept, txRr);
    sc      = 2'h0;
    for (int c = 0; c < NC; c++) begin
      if (ucCnt[sp][c] != 8'h00 || mqCnt[sp][c] != '0) sc = 2'(c);
    end
    mcF   = mqMem[sp][sc][mqRd[sp][sc]];
    useMc = (mqCnt[sp][sc] != '0) && (ucCnt[sp][sc] == 8'h00 ||
            (8'(seq - fcbStamp[mcF]) > 8'(seq - fcbStamp[ucHead[sp][sc]])));
    deqF  = useMc ? mcF : ucHead[sp][sc];
    txFinal  = (txState == TX_SEND) & txAccept[txPort] & (txLeft <= 13'(WORD_BYTES));
    lastCopy = ~fcbMc[txFcb] | (fcbCopies[txFcb] <= 3'h1);
  end
  // ****************************************
  // release arbitration
  // ****************************************
  logic          relAny;
  logic [FW-1:0] relF;
  // round robin over pending release handles
  always_comb begin
    relAny = |fcbRel;
    relF   = relPtr;
    for (int i = NFCB; i >= 1; i--) begin
      if (fcbRel[FW'(int'(relPtr) + i)]) relF = FW'(int'(relPtr) + i);
    end
  end
  // ****************************************
  // free block list
  // ****************************************
  // start-up chaining, allocation and chain return
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      initDone <= 1'b0;
      initIdx  <= '0;
      freeHead <= '0;
      freeCnt  <= '0;
    end else if (!initDone) begin
      initIdx <= initIdx + 1'b1;
      if (initIdx == BW'(NBLK - 1)) begin
        initDone <= 1'b1;
        freeCnt  <= (BW+1)'(NBLK);
      end
    end else begin
      if (relAny) freeHead <= fcbHead[relF];
      else if (alloc) freeHead <= nextBlk[freeHead];
      freeCnt <= freeCnt - (alloc ? (BW+1)'(1) : '0) + (relAny ? fcbBlks[relF] : '0);
    end
  end
  // block links
  always_ff @(posedge mclk) begin
    if (!initDone) nextBlk[initIdx] <= initIdx + 1'b1;
    if (rxRoll) nextBlk[rxBlk] <= freeHead;
    if (initDone && relAny) nextBlk[fcbTail[relF]] <= alloc ? nextBlk[freeHead] : freeHead;
  end
  // ****************************************
  // control block pool
  // ****************************************
  // handle allocation, release requests, service
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fcbUsed <= '0;
      fcbRel  <= '0;
      relPtr  <= '0;
    end else begin
      if (initDone && relAny) begin
        fcbRel[relF]  <= 1'b0;
        fcbUsed[relF] <= 1'b0;
        relPtr        <= relF;
      end
      if (rxGrant) fcbUsed[freeF] <= 1'b1;
      if (rxDone && rxBad) fcbRel[rxFcb] <= 1'b1;
      if (rspDrop) fcbRel[rspFcb] <= 1'b1;
      if (txFinal && lastCopy) fcbRel[txFcb] <= 1'b1;
    end
  end
  // control block fields
  always_ff @(posedge mclk) begin
    if (rxGrant) fcbHead[freeF] <= freeHead;
    if (rxDone) begin
      fcbTail[rxFcb] <= rxBlk;
      fcbBlks[rxFcb] <= rxBlks;
      fcbLen[rxFcb]  <= rxLenNext;
      fcbSrc[rxFcb]  <= rxPort;
    end
    if (rspKeep) begin
      fcbMc[rspFcb]     <= rspMcast;
      fcbCopies[rspFcb] <= rspMcast ? copies : 3'h1;
      fcbStamp[rspFcb]  <= seq;
      if (!rspMcast && ucCnt[ucDest][portCls(ucDest, rspClass)] != 8'h00)
        fcbNext[ucTail[ucDest][portCls(ucDest, rspClass)]] <= rspFcb;
    end
    if (txFinal && !lastCopy) fcbCopies[txFcb] <= fcbCopies[txFcb] - 3'h1;
  end
  // ****************************************
  // receive mover
  // ****************************************
  // port lock from start to end of frame, block roll-over, checks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxBusy   <= 1'b0;
      rxReady  <= '0;
      rxPort   <= '0;
      rxRr     <= '0;
      rxFcb    <= '0;
      rxBlk    <= '0;
      rxBlks   <= '0;
      rxWord   <= 4'h0;
      rxLen    <= 13'h0000;
      rxErr    <= 1'b0;
      rxTag    <= 1'b0;
      srchReq  <= 1'b0;
      srchPort <= '0;
      srchFcb  <= '0;
    end else begin
      srchReq <= rxDone & ~rxBad;
      if (rxDone) begin
        srchPort <= rxPort;
        srchFcb  <= rxFcb;
      end
      if (rxGrant) begin
        rxBusy  <= 1'b1;
        rxPort  <= rxPick;
        rxRr    <= rxPick;
        rxReady <= NP'(1) << rxPick;
        rxFcb   <= freeF;
        rxBlk   <= freeHead;
        rxBlks  <= (BW+1)'(1);
        rxWord  <= 4'h0;
        rxLen   <= 13'h0000;
        rxErr   <= 1'b0;
        rxTag   <= 1'b0;
      end else if (rxAcc) begin
        rxWord <= rxWord + 4'h1;
        rxLen  <= rxLenNext;
        if (rxWord == 4'h1 && rxBlks == (BW+1)'(1))
          rxTag <= rxData[rxPort][39:32] == TPID_HI && rxData[rxPort][47:40] == TPID_LO;
        if (rxBad) rxErr <= 1'b1;
        if (rxRoll) begin
          rxBlk  <= freeHead;
          rxBlks <= rxBlks + 1'b1;
        end
        if (rxEof[rxPort]) begin
          rxBusy  <= 1'b0;
          rxReady <= '0;
        end
      end
    end
  end
  // buffer capture, header from the first block only (word count wraps per block)
  always_ff @(posedge mclk) begin
    if (rxAcc && !rxErr) frameMem[{rxBlk, rxWord}] <= rxData[rxPort];
    if (rxAcc && !rxWord[3] && rxBlks == (BW+1)'(1))
      hdrMem[{rxFcb, rxWord[2:0]}] <= rxData[rxPort];
  end
  // ****************************************
  // queue manager
  // ****************************************
  // unicast lists and multicast queues per port and class
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq <= 8'h00;
      for (int p = 0; p < NP; p++) begin
        for (int c = 0; c < NC; c++) begin
          ucHead[p][c] <= '0;
          ucTail[p][c] <= '0;
          ucCnt[p][c]  <= 8'h00;
          mqRd[p][c]   <= '0;
          mqWr[p][c]   <= '0;
          mqCnt[p][c]  <= '0;
        end
      end
    end else begin
      if (rspKeep) seq <= seq + 8'h01;
      for (int p = 0; p < NP; p++) begin
        for (int c = 0; c < NC; c++) begin
          logic enqU, enqM, deqU, deqM;
          enqU = rspKeep && !rspMcast && ucDest == PW'(p) && portCls(p, rspClass) == 2'(c);
          enqM = rspKeep && rspMcast && rspPorts[p] && portCls(p, rspClass) == 2'(c);
          deqU = schedGo && !useMc && sp == PW'(p) && sc == 2'(c);
          deqM = schedGo && useMc && sp == PW'(p) && sc == 2'(c);
          if (enqU) ucTail[p][c] <= rspFcb;
          if (enqU && (ucCnt[p][c] == 8'h00 || (deqU && ucCnt[p][c] == 8'h01)))
            ucHead[p][c] <= rspFcb;
          else if (deqU) ucHead[p][c] <= fcbNext[ucHead[p][c]];
          ucCnt[p][c] <= ucCnt[p][c] + (enqU ? 8'h01 : 8'h00) - (deqU ? 8'h01 : 8'h00);
          if (enqM) mqWr[p][c] <= mqWr[p][c] + 1'b1;
          if (deqM) mqRd[p][c] <= mqRd[p][c] + 1'b1;
          mqCnt[p][c] <= mqCnt[p][c] + (enqM ? (MW+1)'(1) : '0) - (deqM ? (MW+1)'(1) : '0);
        end
      end
    end
  end
  // multicast queue entries
  always_ff @(posedge mclk) begin
    for (int p = 0; p < NP; p++) begin
      if (rspKeep && rspMcast && rspPorts[p])
        mqMem[p][portCls(p, rspClass)][mqWr[p][portCls(p, rspClass)]] <= rspFcb;
    end
  end
  // source flow control: raised on congestion, dropped when relieved
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) fcPause <= '0;
    else if (rspValid && congested && srcFc) fcPause[fcbSrc[rspFcb]] <= 1'b1;
    else if (!anyCong && !shortBuf) fcPause <= '0;
  end
  // ****************************************
  // port control and transmit mover
  // ****************************************
  // frame load, address walk, start and end flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txState     <= TX_IDLE;
      txFcb       <= '0;
      txBlk       <= '0;
      txWord      <= 4'h0;
      txLeft      <= 13'h0000;
      txFirst     <= 1'b0;
      txRr        <= '0;
      txPort      <= '0;
      txValid     <= 1'b0;
      txData      <= 64'h0;
      txSof       <= 1'b0;
      txEof       <= 1'b0;
      txLastBytes <= 3'h0;
    end else begin
      txValid <= 1'b0;
      unique case (txState)
        TX_IDLE: begin
          if (schedGo) begin
            txState <= TX_SEND;
            txFcb   <= deqF;
            txBlk   <= fcbHead[deqF];
            txLeft  <= fcbLen[deqF];
            txWord  <= 4'h0;
            txFirst <= 1'b1;
            txPort  <= sp;
            txRr    <= sp;
          end
        end
        TX_SEND: begin
          if (txAccept[txPort]) begin
            txData      <= frameMem[{txBlk, txWord}];
            txValid     <= 1'b1;
            txSof       <= txFirst;
            txEof       <= txFinal;
            txLastBytes <= txFinal ? txLeft[2:0] : 3'h0;
            txFirst     <= 1'b0;
            txLeft      <= txLeft - 13'(WORD_BYTES);
            txWord      <= txWord + 4'h1;
            if (txWord == 4'hF) txBlk <= nextBlk[txBlk];
            if (txFinal) txState <= TX_IDLE;
          end
        end
      endcase
    end
  end
  // ****************************************
  // register port and search header read
  // ****************************************
  // writes steer limits and per-port control, reads show state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      portCtrl <= {NP{PCTL_RST}};
      bufLimit <= BUF_LIMIT_RST;
      qLimit   <= QLIMIT_RST;
      reserve  <= RESERVE_RST;
      dropCnt  <= 16'h0000;
      regRdata <= 16'h0000;
      srchHdr  <= 64'h0;
    end else begin
      srchHdr <= hdrMem[{srchHdrFcb, srchHdrIdx}];
      if (rspDrop) dropCnt <= dropCnt + 16'h0001;
      if (regWr) begin
        if (regAddr < REG_BUF_LIMIT) portCtrl[regAddr[1:0]] <= regWdata[1:0];
        if (regAddr == REG_BUF_LIMIT) bufLimit <= regWdata[12:0];
        if (regAddr == REG_QLIMIT) qLimit <= regWdata[7:0];
        if (regAddr == REG_RESERVE) reserve <= regWdata[7:0];
      end
      regRdata <= 16'h0000;
      if (regRd) begin
        if (regAddr < REG_BUF_LIMIT) regRdata <= {14'h0000, portCtrl[regAddr[1:0]]};
        if (regAddr == REG_BUF_LIMIT) regRdata <= {3'h0, bufLimit};
        if (regAddr == REG_QLIMIT) regRdata <= {8'h00, qLimit};
        if (regAddr == REG_RESERVE) regRdata <= {8'h00, reserve};
        if (regAddr == REG_FREE) regRdata <= 16'(freeCnt);
        if (regAddr == REG_DROPS) regRdata <= dropCnt;
        if (regAddr == REG_STATUS) regRdata <= {11'h000, fcPause, initDone};
      end
    end
  end
endmodule : sfe_frame_engine
`default_nettype wire

// ---- sfe_props.sv ----
/* sfe_props: port assertions of the frame engine
   assumes a bind onto sfe_frame_engine, one clock mclk */
`timescale 1ns/100ps
`default_nettype none
module sfe_props import sfe_pkg::*; #(parameter int NBLK = 64) (
  input wire logic          mclk, rst, regRd, srchReq, txValid, txEof,
  input wire logic [15:0]   regRdata,
  input wire logic [PW-1:0] srchPort,
  input wire logic [NP-1:0] rxValid, rxSof, rxEof, rxGood, rxReady);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  int cnt;
  wire [NP-1:0] take = rxValid & rxReady;
  logic [NP-1:0] endGood;
  // good end-of-frame words taken last cycle, by port
  always_ff @(posedge mclk or posedge rst)
    if (rst) endGood <= '0;
    else endGood <= take & rxEof & rxGood;
  // cycles since reset release
  always_ff @(posedge mclk or posedge rst) if (rst) cnt <= 0; else if (cnt < NBLK) cnt <= cnt + 1;
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000) else $error("rdata");
  a_grant_onehot: assert property ($onehot0(rxReady)) else $error("grant");
  a_grant_sof: assert property ($rose(|rxReady) |-> $past(|(rxValid & rxSof)))
    else $error("grant without sof");
  a_init_hold: assert property (cnt < NBLK - 1 |-> rxReady == '0) else $error("early");
  a_srch_good: assert property (srchReq |-> endGood[srchPort])
    else $error("bad request");
  a_srch_pulse: assert property (srchReq |=> !srchReq) else $error("request");
  a_rx_release: assert property (|(take & rxEof) |=> rxReady == '0) else $error("ready");
  a_tx_gap: assert property (txValid && txEof |=> !txValid) else $error("tx gap");
  c_req: cover property (srchReq);
  c_tx: cover property (txValid && txEof);
  c_grant: cover property ($rose(|rxReady));
endmodule : sfe_props
bind sfe_frame_engine sfe_props #(.NBLK(NBLK)) sfe_props_inst (.mclk, .rst, .regRd, .srchReq,
  .txValid, .txEof, .regRdata, .srchPort, .rxValid, .rxSof, .rxEof, .rxGood, .rxReady);
`default_nettype wire

// ---- sfe_far_side.sv ----
/* sfe_far_side: search engine model answering each switch request
   assumes requests from sfe_frame_engine on mclk */
`timescale 1ns/100ps
`default_nettype none
module sfe_far_side import sfe_pkg::*; (
  input wire logic          mclk, rst, srchReq,
  input wire logic [3:0]    srchFcb,
  input wire logic [NP-1:0] dest,
  output logic              rspValid, rspMcast, rspDropHigh,
  output logic [3:0]        rspFcb, srchHdrFcb,
  output logic [2:0]        srchHdrIdx,
  output logic [NP-1:0]     rspPorts,
  output logic [1:0]        rspClass);
  logic [2:0] dly;
  // answer three cycles after each request, junk outside it
  always_ff @(posedge mclk or posedge rst) if (rst) dly <= '0; else dly <= {dly[1:0], srchReq};
  assign rspValid = dly[2];
  assign rspFcb = rspValid ? srchFcb : ~srchFcb;
  assign rspPorts = rspValid ? dest : ~dest;
  assign rspMcast = rspValid ? $countones(dest) > 1 : 1'b1;
  assign rspClass = 2'h3;
  assign rspDropHigh = 1'b0;
  assign srchHdrFcb = srchFcb;
  assign srchHdrIdx = 3'h0;
endmodule : sfe_far_side
`default_nettype wire

// ---- testbench.sv ----
/* testbench: register reads, frames in, search header and transmit words out
   assumes sfe_frame_engine with 16 blocks and the sfe_far_side model */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sfe_pkg::*;
  logic mclk = 0, rst = 1, regWr = 0, regRd = 0, srchReq, rspValid, rspMcast, rspDropHigh;
  logic txValid, txSof, txEof;
  logic [3:0] regAddr = '0, srchFcb, srchHdrFcb, rspFcb;
  logic [15:0] regWdata = '0, regRdata;
  logic [NP-1:0] rxValid = '0, rxSof = '0, rxEof = '0, rxGood = '0, rxReady, rspPorts, fcPause;
  logic [NP-1:0] txAccept = '1, dest = 4'h4;
  logic [NP-1:0][63:0] rxData = '0;
  logic [NP-1:0][2:0] rxLastBytes = '0;
  logic [PW-1:0] srchPort, txPort;
  logic [2:0] srchHdrIdx, txLastBytes;
  logic [1:0] rspClass;
  logic [63:0] srchHdr, txData, expq[$];
  int n_mismatch = 0, tests_run = 0, nReq = 0, cyc = 0;
  sfe_frame_engine #(.NBLK(16)) sfe_frame_engine_inst (.mclk, .rst, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .rxValid, .rxData, .rxSof, .rxEof, .rxGood, .rxLastBytes, .rxReady,
    .srchReq, .srchPort, .srchFcb, .srchHdrFcb, .srchHdrIdx, .srchHdr, .rspValid, .rspFcb, .rspMcast,
    .rspPorts, .rspClass, .rspDropHigh, .fcPause, .txAccept, .txValid, .txPort, .txData, .txSof,
    .txEof, .txLastBytes);
  sfe_far_side sfe_far_side_inst (.mclk, .rst, .srchReq, .srchFcb, .dest, .rspValid, .rspMcast,
    .rspDropHigh, .rspFcb, .srchHdrFcb, .srchHdrIdx, .rspPorts, .rspClass);
  initial forever #4 mclk = ~mclk;
  task chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task stop_test;
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk(64'(regRdata), 64'(e));
  endtask : rd
  // send n words from port p, cp copies expected out
  task frame(input int p, n, input logic good, input int cp);
    int k, r;
    logic g;
    k = 0;
    r = nReq;
    while (k < n) begin
      @(posedge mclk);
      rxValid[p] <= 1'b1;
      rxSof[p] <= k == 0;
      rxEof[p] <= k == n - 1;
      rxGood[p] <= good;
      rxData[p] <= 64'(k * 3 + p);
      @(negedge mclk) g = rxReady[p];
      if (g) k++;
    end
    @(posedge mclk) rxValid[p] <= 1'b0;
    repeat (cp) for (int i = 0; i < n; i++) expq.push_back({i == 0, i == n - 1, 62'(i * 3 + p)});
    @(posedge mclk) #1 chk(64'(nReq - r), 64'(cp > 0));
    if (cp > 0) chk(srchHdr, 64'(p));
    if (cp > 0) chk(64'(srchPort), 64'(p));
    for (k = 0; k < 900 && expq.size(); k++) @(posedge mclk);
    repeat (6) @(posedge mclk);
  endtask : frame
  // counts requests, compares each transmit word, cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (srchReq) nReq++;
    if (txValid) begin
      chk({txSof, txEof, txData[61:0]}, expq.size() ? expq.pop_front() : '1);
      chk(64'(txLastBytes), 64'h0);
      chk(64'(dest[txPort]), 64'h1);
    end
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_BUF_LIMIT, 16'h1000);
    rd(4'hF, 16'h0000);
    repeat (20) @(posedge mclk);
    rd(REG_FREE, 16'h0010);
    frame(0, 3, 1, 1);
    frame(1, 2, 0, 0);
    dest <= 4'h6;
    frame(3, 20, 1, 2);
    dest <= 4'h4;
    frame(0, 191, 1, 0);
    @(posedge mclk);
    regWdata <= 16'h0002;
    regAddr <= REG_PORT0;
    regWr <= 1'b1;
    @(posedge mclk) regWr <= 1'b0;
    frame(0, 191, 1, 1);
    rd(REG_FREE, 16'h0010);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
